// *** smod_top.sv ***
`timescale 1ns/1ps
// Purpose: stop mode control and main oscillator stop detection
// Assumes: Avalon-MM slave, inputs synchronous to clk_sys
// Notes:   wake requests are level inputs from the peripherals
//
// Overview of operation
// - stop mode halts all oscillators except the watchdog oscillator
// - peripherals on external clocks keep running in stop mode
// - wake sources: key, unfiltered pins, timer, ext-clock serial, usb resume
// - voltage monitors wake only with their filter-disable bit set
// - writing all-clock-stop enters stop and sets divide-by-eight
// - ports hold; crystal drive high or input per pin function bit
// - stop mode ends on reset or enabled peripheral interrupt
// - interrupt sequence runs once request is up and clock restarts
// - after interrupt wake cpu clock is previous clock divided by eight
// - detection runs only with enables 11b and crystal at 2 MHz up
// - crystal stop sets fallback, stopped flag, clears ls stop, interrupts
// - shared vector; source told by stopped flag or enables with fallback
module smod_top
	import smod_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 sys_rst,
	input  wire logic                 clkEn,
	input  wire logic [3:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	input  wire logic                 xtalEdge,
	input  wire logic                 lsTick,
	input  wire logic                 xtalIsCpuSrc,
	input  wire logic [WAKE_SRCS-1:0] wakeReq,
	input  wire logic                 vmon1Req,
	input  wire logic                 vmon2Req,
	input  wire logic                 vmon1FilterDisable,
	input  wire logic                 vmon2FilterDisable,
	input  wire logic                 vmon1DetectFlag,
	input  wire logic                 vmon2DetectFlag,
	input  wire logic                 watchdogUnderflowFlag,
	input  wire logic                 extClockedEn,
	input  wire logic                 portOut,
	output logic                      oscRunEn,
	output logic                      cpuClkEn,
	output logic                      periphClkEn,
	output logic                      extPeriphEn,
	output logic                      portHold,
	output logic                      xtalDriveOut,
	output logic                      xtalDriveOe_n,
	output logic                      intSeqStart,
	output logic                      sharedIrq,
	output logic                      oscStopSrc
);
	smod_state_t state_r;
	logic [9:0]  ctrl_r;
	logic [3:0]  oscDet_r;
	logic [WAKE_SRCS-1:0] wakeEn_r;
	logic        ackPend_r;
	logic        xtalHold_r;
	logic        wakeHit;
	logic        clkWr;
	smod_det_if  detBus();

	smod_osc_det smod_osc_det_inst (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.clkEn   (clkEn),
		.det     (detBus.det)
	);

	// armed only with both enables set and crystal feeding the cpu
	assign detBus.armed    = (oscDet_r[B_ENHI:B_ENLO] == DET_ON) && xtalIsCpuSrc
		&& state_r == SMOD_RUN;
	assign detBus.xtalEdge = xtalEdge;
	assign detBus.lsTick   = lsTick;

	// wake vector: key, pins, timer, serial, usb resume per wakeEn_r mask
	assign wakeHit = |(wakeReq & wakeEn_r)
		|| (vmon1Req && vmon1FilterDisable)
		|| (vmon2Req && vmon2FilterDisable);

	// one-cycle answer; a frozen clock enable also holds the bus
	assign avs_waitrequest = (avs_read || avs_write) && !(ackPend_r && clkEn);
	assign clkWr = avs_write && ackPend_r && clkEn;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			ackPend_r <= 1'b0;
		else if (clkEn)
			ackPend_r <= (avs_read || avs_write) && !ackPend_r;
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			avs_readdata <= 32'h0000_0000;
		else if (clkEn && avs_read && !ackPend_r)
		begin
			unique case (avs_address)
				ADDR_CTRL:   avs_readdata <= {22'h000000, ctrl_r};
				ADDR_OSCDET: avs_readdata <= {28'h0000000, oscDet_r};
				ADDR_WAKE:   avs_readdata <= {24'h000000, wakeEn_r};
				ADDR_STATUS: avs_readdata <= {27'h0000000, watchdogUnderflowFlag,
					vmon2DetectFlag, vmon1DetectFlag, oscStopSrc, state_r == SMOD_STOP};
				default:     avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// control register; the unlock bit itself is always writable
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			ctrl_r <= CTRL_RST;
		else if (clkEn)
		begin
			if (clkWr && avs_address == ADDR_CTRL)
			begin
				if (ctrl_r[B_UNLOCK])
				begin
					ctrl_r <= avs_writedata[9:0];
					if (avs_writedata[B_ALLSTOP])
						ctrl_r[B_DIV8] <= 1'b1;
				end
				else
					ctrl_r[B_UNLOCK] <= avs_writedata[B_UNLOCK];
			end
			else if (state_r == SMOD_STOP && wakeHit)
			begin
				ctrl_r[B_ALLSTOP] <= 1'b0;
				ctrl_r[B_DIV8]    <= 1'b1;
			end
			if (detBus.stopSeen)
				ctrl_r[B_LSSTOP] <= 1'b0;
		end
	end

	// detect register; hardware set wins over a software write
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			oscDet_r <= OSCDET_RST;
		else if (clkEn)
		begin
			if (clkWr && avs_address == ADDR_OSCDET && ctrl_r[B_UNLOCK])
				oscDet_r <= avs_writedata[3:0];
			if (detBus.stopSeen)
			begin
				oscDet_r[B_FALLBACK] <= 1'b1;
				oscDet_r[B_STOPPED]  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			wakeEn_r <= '0;
		else if (clkEn && clkWr && avs_address == ADDR_WAKE)
			wakeEn_r <= avs_writedata[WAKE_SRCS-1:0];
	end

	// power state machine
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			state_r <= SMOD_RUN;
		else if (clkEn)
		begin
			unique case (state_r)
				SMOD_RUN:
					if (clkWr && avs_address == ADDR_CTRL && ctrl_r[B_UNLOCK]
						&& avs_writedata[B_ALLSTOP])
						state_r <= SMOD_STOP;
				SMOD_STOP:
					if (wakeHit)
						state_r <= SMOD_WAKE;
				SMOD_WAKE:
					state_r <= SMOD_RUN;
				default:
					state_r <= SMOD_RUN;
			endcase
		end
	end

	// crystal pin level caught at entry so the hold ignores later changes
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			xtalHold_r <= 1'b0;
		else if (clkEn && state_r == SMOD_RUN)
			xtalHold_r <= portOut;
	end

	assign oscRunEn     = state_r != SMOD_STOP;
	assign cpuClkEn     = state_r != SMOD_STOP;
	assign periphClkEn  = state_r != SMOD_STOP;
	assign extPeriphEn  = extClockedEn;
	assign portHold     = state_r == SMOD_STOP;
	assign intSeqStart  = state_r == SMOD_WAKE;

	// crystal pin in stop: held high when in oscillator role, else released as input; outside stop drives xtalHold_r
	always_comb
	begin
		if (state_r == SMOD_STOP)
		begin
			xtalDriveOut  = ctrl_r[B_XPINFN];
			xtalDriveOe_n = !ctrl_r[B_XPINFN];
		end
		else
		begin
			xtalDriveOut  = xtalHold_r;
			xtalDriveOe_n = 1'b0;
		end
	end

	// shared vector source decode
	assign oscStopSrc = oscDet_r[B_STOPPED]
		|| (oscDet_r[B_ENHI:B_ENLO] == DET_ON && oscDet_r[B_FALLBACK]);
	assign sharedIrq  = (oscStopSrc && oscDet_r[B_ENHI:B_ENLO] == DET_ON)
		|| watchdogUnderflowFlag || vmon1DetectFlag || vmon2DetectFlag;

	a_stop_entry: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && state_r == SMOD_RUN && clkWr && avs_address == ADDR_CTRL
		&& ctrl_r[B_UNLOCK] && avs_writedata[B_ALLSTOP]
		|=> state_r == SMOD_STOP && ctrl_r[B_DIV8])
		else $error("stop entry did not set divide-by-eight");
	a_clocks_halted: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && state_r == SMOD_STOP && !wakeHit |=> !cpuClkEn && !oscRunEn && !periphClkEn)
		else $error("clock running in stop mode");
	a_locked_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && clkWr && avs_address == ADDR_OSCDET && !ctrl_r[B_UNLOCK]
		&& !detBus.stopSeen |=> $stable(oscDet_r))
		else $error("locked write changed detect register");
	a_wake_path: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && state_r == SMOD_STOP && wakeHit |=> intSeqStart)
		else $error("wake did not start interrupt sequence");
	a_wake_div8: assert property (@(posedge clk_sys) disable iff (sys_rst)
		state_r == SMOD_WAKE |-> ctrl_r[B_DIV8] && !ctrl_r[B_ALLSTOP])
		else $error("wake clock not divided by eight");
	a_vmon_filter: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && state_r == SMOD_STOP && !(|(wakeReq & wakeEn_r))
		&& !vmon1FilterDisable && !vmon2FilterDisable |=> state_r == SMOD_STOP)
		else $error("filtered monitor woke the device");
	a_xtal_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		state_r == SMOD_STOP && ctrl_r[B_XPINFN] |-> xtalDriveOut && !xtalDriveOe_n)
		else $error("crystal drive not held high");
	a_detect_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && detBus.stopSeen |=> oscDet_r[B_STOPPED] && oscDet_r[B_FALLBACK]
		&& !ctrl_r[B_LSSTOP] && sharedIrq)
		else $error("oscillator stop not flagged");
	a_detect_armed: assert property (@(posedge clk_sys) disable iff (sys_rst)
		detBus.stopSeen |-> oscDet_r[B_ENHI:B_ENLO] == DET_ON)
		else $error("detection outside enabled setting");

	c_stop_wake: cover property (@(posedge clk_sys) disable iff (sys_rst)
		state_r == SMOD_STOP ##[1:20] state_r == SMOD_WAKE);
	c_osc_stop: cover property (@(posedge clk_sys) disable iff (sys_rst)
		detBus.stopSeen);
	c_locked: cover property (@(posedge clk_sys) disable iff (sys_rst)
		clkWr && !ctrl_r[B_UNLOCK]);
endmodule

// *** smod_pkg.sv ***
// Purpose: shared constants for stop mode and oscillation stop detection
// Assumes: 20 MHz system clock, Avalon-MM register access
// Notes:   byte addresses, one 32-bit word per register
package smod_pkg;
	localparam int unsigned CLK_HZ          = 20000000;
	localparam logic [3:0]  ADDR_CTRL       = 4'h0;
	localparam logic [3:0]  ADDR_OSCDET     = 4'h4;
	localparam logic [3:0]  ADDR_WAKE       = 4'h8;
	localparam logic [3:0]  ADDR_STATUS     = 4'hC;
	// control register bit positions
	localparam int          B_ALLSTOP       = 0;
	localparam int          B_DIV8          = 1;
	localparam int          B_DIVLO         = 2;
	localparam int          B_DIVHI         = 3;
	localparam int          B_OVERRIDE      = 4;
	localparam int          B_XPINFN        = 5;
	localparam int          B_LSSTOP        = 6;
	localparam int          B_UNLOCK        = 7;
	localparam int          B_HSON          = 8;
	localparam int          B_HSSEL         = 9;
	// oscillation detect register bit positions
	localparam int          B_ENLO          = 0;
	localparam int          B_ENHI          = 1;
	localparam int          B_FALLBACK      = 2;
	localparam int          B_STOPPED       = 3;
	localparam logic [9:0]  CTRL_RST        = 10'h048;
	localparam logic [3:0]  OSCDET_RST      = 4'h0;
	localparam logic [1:0]  DET_ON          = 2'h3;
	localparam int          WAKE_SRCS       = 8;
	// detection window measured in low-speed oscillator ticks
	localparam logic [7:0]  DET_WINDOW      = 8'h08;
	typedef enum logic [1:0] {SMOD_RUN, SMOD_STOP, SMOD_WAKE} smod_state_t;
endpackage

// *** smod_det_if.sv ***
`timescale 1ns/1ps
// Purpose: carries detector control and result between top and detector
// Assumes: single clock domain
// Notes:   none
interface smod_det_if;
	logic armed;
	logic xtalEdge;
	logic lsTick;
	logic stopSeen;
	modport top (output armed, output xtalEdge, output lsTick, input stopSeen);
	modport det (input armed, input xtalEdge, input lsTick, output stopSeen);
endinterface

// *** smod_osc_det.sv ***
`timescale 1ns/1ps
// Purpose: watches the main crystal for missing edges
// Assumes: edge and tick inputs are one-cycle pulses
// Notes:   window counted in low-speed oscillator ticks
module smod_osc_det
	import smod_pkg::*;
(
	input  wire logic   clk_sys,
	input  wire logic   sys_rst,
	input  wire logic   clkEn,
	smod_det_if.det     det
);
	logic [7:0] tickCnt_r;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			tickCnt_r <= 8'h00;
		else if (clkEn)
		begin
			if (!det.armed || det.xtalEdge)
				tickCnt_r <= 8'h00;
			else if (det.lsTick && tickCnt_r != DET_WINDOW)
				tickCnt_r <= tickCnt_r + 8'h01;
		end
	end

	// pulse only on reaching the window edge
	assign det.stopSeen = det.armed && det.lsTick && !det.xtalEdge
		&& (tickCnt_r == DET_WINDOW - 8'h01);

	a_det_window: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clkEn && det.armed && det.xtalEdge |=> tickCnt_r == 8'h00)
		else $error("crystal edge did not restart the window");
endmodule

// *** smod_top_tb.sv ***
// Purpose: self-checking bench for stop mode and oscillator stop detection
// Assumes: one 20 MHz clock, Avalon-MM master tasks, no partner model
// Notes:   expected values queued by the driver, compared by a monitor
`timescale 1ns/1ps
module smod_top_tb
	import smod_pkg::*;
;
	logic                 clk_sys, sys_rst, clkEn, avs_read, avs_write;
	logic [3:0]           avs_address;
	logic [31:0]          avs_writedata, avs_readdata, q;
	logic                 avs_waitrequest, xtalEdge, lsTick, xtalIsCpuSrc;
	logic [WAKE_SRCS-1:0] wakeReq, mask;
	logic                 vmon1Req, vmon2Req, vmon1FilterDisable, vmon2FilterDisable;
	logic                 vmon1DetectFlag, vmon2DetectFlag, watchdogUnderflowFlag;
	logic                 extClockedEn, portOut, oscRunEn, cpuClkEn, periphClkEn;
	logic                 extPeriphEn, portHold, xtalDriveOut, xtalDriveOe_n;
	logic                 intSeqStart, sharedIrq, oscStopSrc, tickOn, xtalOn, pin, ext;
	logic [7:0]           tickCnt;
	logic [31:0]          expQ[$], obsQ[$];
	event                 resEv;
	int                   n_fail, num_checks, seed, n;
	wire  [6:0]           pins = {oscRunEn, cpuClkEn, periphClkEn, portHold,
	                              xtalDriveOut, xtalDriveOe_n, extPeriphEn};

	smod_top smod_top_inst (
		.clk_sys               (clk_sys),
		.sys_rst               (sys_rst),
		.clkEn                 (clkEn),
		.avs_address           (avs_address),
		.avs_read              (avs_read),
		.avs_write             (avs_write),
		.avs_writedata         (avs_writedata),
		.avs_readdata          (avs_readdata),
		.avs_waitrequest       (avs_waitrequest),
		.xtalEdge              (xtalEdge),
		.lsTick                (lsTick),
		.xtalIsCpuSrc          (xtalIsCpuSrc),
		.wakeReq               (wakeReq),
		.vmon1Req              (vmon1Req),
		.vmon2Req              (vmon2Req),
		.vmon1FilterDisable    (vmon1FilterDisable),
		.vmon2FilterDisable    (vmon2FilterDisable),
		.vmon1DetectFlag       (vmon1DetectFlag),
		.vmon2DetectFlag       (vmon2DetectFlag),
		.watchdogUnderflowFlag (watchdogUnderflowFlag),
		.extClockedEn          (extClockedEn),
		.portOut               (portOut),
		.oscRunEn              (oscRunEn),
		.cpuClkEn              (cpuClkEn),
		.periphClkEn           (periphClkEn),
		.extPeriphEn           (extPeriphEn),
		.portHold              (portHold),
		.xtalDriveOut          (xtalDriveOut),
		.xtalDriveOe_n         (xtalDriveOe_n),
		.intSeqStart           (intSeqStart),
		.sharedIrq             (sharedIrq),
		.oscStopSrc            (oscStopSrc)
	);

	always #25 clk_sys = ~clk_sys;

	// free-running low-speed ticks every 4 cycles, crystal edges every 2
	always @(posedge clk_sys)
	begin
		if (sys_rst)
			tickCnt <= 8'h00;
		else
			tickCnt <= tickCnt + 8'h01;
		lsTick <= tickOn && tickCnt[1:0] == 2'h0;
		xtalEdge <= xtalOn && tickCnt[0];
	end

	task cmp(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task note(input logic [31:0] seen, input logic [31:0] exp);
		obsQ.push_back(seen);
		expQ.push_back(exp);
		->resEv;
	endtask

	always @(resEv)
		while (expQ.size() > 0)
			cmp(obsQ.pop_front(), expQ.pop_front());

	// holds the request until waitrequest is seen low at a rising edge
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		note(q, exp);
	endtask

	task waitEdges(input int k);
		repeat (k) @(negedge clk_sys);
	endtask

	task results;
		while (expQ.size() > 0)
			cmp(obsQ.pop_front(), expQ.pop_front());
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// budget is far above the expected run of a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		$display("watchdog expired");
		results();
	end

	initial
	begin
		{clk_sys, avs_read, avs_write, avs_address, avs_writedata, xtalIsCpuSrc} = '0;
		{wakeReq, vmon1Req, vmon2Req, vmon1FilterDisable, vmon2FilterDisable} = '0;
		{vmon1DetectFlag, vmon2DetectFlag, watchdogUnderflowFlag, portOut} = '0;
		{extClockedEn, tickOn, xtalOn, n_fail, num_checks} = '0;
		seed = 32'h557c;
		clkEn = 1'b1;
		sys_rst = 1'b1;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(ADDR_CTRL, {22'h0, CTRL_RST});
		rd(ADDR_OSCDET, 32'h0);
		rd(ADDR_WAKE, 32'h0);
		rd(4'h1, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h004);
		bus(1'b1, ADDR_OSCDET, 32'h3);
		rd(ADDR_CTRL, {22'h0, CTRL_RST});
		rd(ADDR_OSCDET, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h080);
		rd(ADDR_CTRL, {22'h0, CTRL_RST} | 32'h080);
		bus(1'b1, ADDR_CTRL, 32'h08C);
		rd(ADDR_CTRL, 32'h08C);
		// frozen clock enable must stretch the bus answer
		clkEn <= 1'b0;
		fork
			bus(1'b1, ADDR_WAKE, 32'h0A5);
			begin
				repeat (4) @(posedge clk_sys);
				clkEn <= 1'b1;
			end
		join
		rd(ADDR_WAKE, 32'h0A5);
		$display("lock test done");
		for (int it = 0; it < 4; it++)
		begin
			mask = 8'($random(seed));
			mask[it] = 1'b1;
			mask[it + 4] = 1'b0;
			pin = it[0];
			ext = 1'($random(seed));
			@(posedge clk_sys);
			extClockedEn <= ext;
			portOut <= 1'($random(seed));
			bus(1'b1, ADDR_WAKE, {24'h0, mask});
			bus(1'b1, ADDR_CTRL, 32'h0C1 | (pin << 5));
			waitEdges(1);
			note(pins, {4'b0001, pin, !pin, ext});
			rd(ADDR_CTRL, 32'h0C3 | (pin << 5));
			rd(ADDR_STATUS, 32'h1);
			@(posedge clk_sys);
			wakeReq <= 8'h01 << (it + 4);
			waitEdges(6);
			note(portHold, 1'b1);
			if (it < 2)
			begin
				{vmon2Req, vmon1Req} <= 2'b01 << it;
				waitEdges(6);
				note(portHold, 1'b1);
				@(posedge clk_sys);
				{vmon2FilterDisable, vmon1FilterDisable} <= 2'b01 << it;
			end
			else
			begin
				@(posedge clk_sys);
				wakeReq <= wakeReq | (8'h01 << it);
			end
			n = 0;
			do
			begin
				@(negedge clk_sys);
				n++;
			end
			while (intSeqStart !== 1'b1 && n < 20);
			note(intSeqStart, 1'b1);
			waitEdges(1);
			note({intSeqStart, cpuClkEn, portHold, xtalDriveOut}, {3'b010, portOut});
			@(posedge clk_sys);
			{wakeReq, vmon1Req, vmon2Req, vmon1FilterDisable, vmon2FilterDisable} <= '0;
			rd(ADDR_CTRL, 32'h0C2 | (pin << 5));
			$display("stop test %0d done", it);
		end
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk_sys);
			{watchdogUnderflowFlag, vmon2DetectFlag, vmon1DetectFlag} <= 3'b001 << k;
			rd(ADDR_STATUS, 32'h4 << k);
			note(sharedIrq, 1'b1);
		end
		@(posedge clk_sys);
		{watchdogUnderflowFlag, vmon2DetectFlag, vmon1DetectFlag} <= 3'b000;
		waitEdges(2);
		note(sharedIrq, 1'b0);
		$display("shared vector test done");
		bus(1'b1, ADDR_CTRL, 32'h0C2);
		xtalOn <= 1'b1;
		tickOn <= 1'b1;
		repeat (8) @(posedge clk_sys);
		xtalIsCpuSrc <= 1'b1;
		bus(1'b1, ADDR_OSCDET, 32'h3);
		waitEdges(60);
		rd(ADDR_OSCDET, 32'h3);
		note({sharedIrq, oscStopSrc}, 2'b00);
		bus(1'b1, ADDR_OSCDET, 32'h1);
		xtalOn <= 1'b0;
		waitEdges(60);
		rd(ADDR_OSCDET, 32'h1);
		bus(1'b1, ADDR_OSCDET, 32'h3);
		waitEdges(60);
		rd(ADDR_OSCDET, 32'hF);
		rd(ADDR_CTRL, 32'h082);
		rd(ADDR_STATUS, 32'h2);
		note({sharedIrq, oscStopSrc}, 2'b11);
		$display("detector test done");
		results();
	end
endmodule
